//--- hw/graphics_memory_write_path.sv
`timescale 1ns/1ns
module graphics_memory_write_path
  import graphics_memory_pkg::*;
#(
  parameter int N_COLS = COLS,
  parameter int N_ROWS = ROWS
) (
  input  wire logic                      clk,           // 20 MHz system clock.
  input  wire logic                      nrst,          // Async reset, low.
  input  wire logic                      clk_en,        // Freezes all state when low.
  input  wire logic [7:0]                reg_addr,      // Register index.
  input  wire logic [PIX_W-1:0]          reg_wdata,     // Register write data.
  input  wire logic                      reg_wr,        // Write strobe.
  input  wire logic                      reg_rd,        // Read strobe.
  output logic [PIX_W-1:0]               reg_rdata,     // Read data, next cycle.
  input  wire logic                      host_select_n, // Host chip select, low.
  input  wire logic                      host_write_n,  // Host write, taken on rise.
  input  wire logic                      host_rs,       // Low index, high data.
  input  wire logic [PIX_W-1:0]          host_data,     // Host data bus.
  input  wire logic                      pixel_clock,   // RGB dot clock.
  input  wire logic                      rgb_enable,    // RGB data enable.
  input  wire logic                      pixel_valid,   // RGB data valid.
  input  wire logic                      frame_sync_n,  // Frame sync, low.
  input  wire logic [PIX_W-1:0]          rgb_pixel_bus, // RGB pixel data.
  output logic [N_COLS*3*CH_W-1:0]       source_out,    // Source channels.
  output logic [N_ROWS-1:0]              gate_on,       // Gate on levels.
  output logic                           line_latched,  // Pulse per latched line.
  output logic                           osc_enable,    // Internal oscillator run.
  output logic                           ext_clock_sel  // External clock chosen.
);

  localparam int NPIX = N_COLS * N_ROWS;
  localparam logic [COL_W-1:0] COL_LAST = COL_W'(N_COLS - 1);
  localparam logic [ROW_W-1:0] ROW_LAST = ROW_W'(N_ROWS - 1);

  typedef struct packed {
    cfg_s             cfg;
    logic [ADR_W-1:0] pixel_address_counter;
    logic [ADR_W-1:0] frame_base;
    logic [7:0]       index_holding_register;
    logic [PIX_W-1:0] rdata;
    host_pins_s       hs1;
    host_pins_s       hs2;
    logic             hwr_prev;
    rgb_pins_s        rs1;
    rgb_pins_s        rs2;
    logic             pclk_prev;
    logic             fs_prev;
    refresh_e         st;
    logic [COL_W-1:0] rf_col;
    logic [ROW_W-1:0] rf_row;
    logic [ROW_W-1:0] gate_row;
    logic             gate_valid;
    logic [N_ROWS-1:0] gate_on;
  } top_s;

  top_s             q;
  top_s             d;
  logic [PIX_W-1:0] graphics_memory [NPIX];
  logic             graphics_memory_we;
  logic [PIX_W-1:0] graphics_memory_wdata;
  logic             host_fire;
  logic             rgb_go;
  logic             fs_fall;
  logic             bus_pix;
  logic             wr_go;
  logic [7:0]       wr_idx;
  logic [PIX_W-1:0] wr_dat;
  logic [PIX_W-1:0] pix_in;
  logic             pix_go;
  pixel_s           rf_pix;

  ////////////////////////////////////////////////////////////////////////////
  // line base and column.
  function automatic logic [ADR_W-1:0] graphics_memory_index(input logic [ADR_W-1:0] a);
    graphics_memory_index = ADR_W'(32'(a[16:8]) * N_COLS + 32'(a[7:0]));
  endfunction

  function automatic logic in_window(input logic [ADR_W-1:0] a, input cfg_s c);
    in_window = a[7:0] >= c.h_start && a[7:0] <= c.h_end
             && a[16:8] >= c.v_start && a[16:8] <= c.v_end;
  endfunction

  // Walks the window so a block of writes fills it row by row.
  function automatic logic [ADR_W-1:0] step_address(input logic [ADR_W-1:0] a, input cfg_s c);
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] row;
    logic             wrap;
    col  = a[7:0];
    row  = a[16:8];
    wrap = 1'b0;
    if (c.scan_step_direction[0]) begin
      if (col >= c.h_end) begin
        col  = c.h_start;
        wrap = 1'b1;
      end else begin
        col = col + 8'h01;
      end
    end else if (col <= c.h_start) begin
      col  = c.h_end;
      wrap = 1'b1;
    end else begin
      col = col - 8'h01;
    end
    if (wrap && c.scan_step_direction[1]) begin
      row = (row >= c.v_end) ? c.v_start : row + 9'h001;
    end else if (wrap) begin
      row = (row <= c.v_start) ? c.v_end : row - 9'h001;
    end
    step_address = {row, col};
  endfunction

  // Contrast stretch per channel, clamped, so channel values of 57 and above saturate at 3Fh.
  function automatic logic [CH_W-1:0] boost(input logic [CH_W-1:0] v);
    logic [7:0] t;
    t = {2'h0, v} + {4'h0, v[5:2]};
    if (t >= ENH_SAT) boost = 6'h3F;
    else if (t <= ENH_OFS) boost = 6'h00;
    else boost = CH_W'(t - ENH_OFS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: pin capture, register decode, pixel path, refresh scan.
  always_comb begin
    d = q;
    graphics_memory_we = 1'b0;
    graphics_memory_wdata = '0;
    wr_go = 1'b0;
    wr_idx = '0;
    wr_dat = '0;
    pix_go = 1'b0;
    pix_in = '0;
    d.hs1 = '{host_select_n, host_write_n, host_rs, host_data};
    d.hs2 = q.hs1;
    d.hwr_prev = q.hs2.write_n;
    d.rs1 = '{pixel_clock, rgb_enable, pixel_valid, frame_sync_n, rgb_pixel_bus};
    d.rs2 = q.rs1;
    d.pclk_prev = q.rs2.pclk;
    d.fs_prev = q.rs2.fsync_n;
    host_fire = !q.hs2.select_n && q.hs2.write_n && !q.hwr_prev;
    fs_fall = q.fs_prev && !q.rs2.fsync_n;
    rgb_go = q.cfg.if_mode == IF_RGB && q.rs2.pclk && !q.pclk_prev && q.rs2.valid
          && q.rs2.enable == q.cfg.enable_polarity;
    // The software port wins a same-cycle clash with a host strobe.
    if (reg_wr) begin
      wr_go = 1'b1;
      wr_idx = reg_addr;
      wr_dat = reg_wdata;
    end else if (host_fire && q.hs2.rs) begin
      wr_go = 1'b1;
      wr_idx = q.index_holding_register;
      wr_dat = q.hs2.data;
    end else if (host_fire) begin
      d.index_holding_register = q.hs2.data[7:0];
    end
    bus_pix = wr_go && wr_idx == IDX_GRAPHICS_MEMORY;
    // RGB capture beats a same-cycle bus pixel; hosts avoid mixing the two.
    if (rgb_go) begin
      pix_go = 1'b1;
      pix_in = q.rs2.bus;
    end else if (bus_pix) begin
      pix_go = 1'b1;
      pix_in = wr_dat;
    end
    if (q.cfg.if_mode == IF_RGB && fs_fall) begin
      d.pixel_address_counter = q.frame_base;
    end else if (pix_go) begin
      graphics_memory_wdata = q.cfg.image_enhancer
                 ? {boost(pix_in[17:12]), boost(pix_in[11:6]), boost(pix_in[5:0])} : pix_in;
      graphics_memory_we = in_window(q.pixel_address_counter, q.cfg);
      d.pixel_address_counter = step_address(q.pixel_address_counter, q.cfg);
    end
    if (wr_go) begin
      case (wr_idx)
        IDX_OUT_CTRL: begin
          d.cfg.source_reverse = wr_dat[OC_SRC_REV];
          d.cfg.colour_order_swap = wr_dat[OC_SWAP];
          d.cfg.gate_scan_reverse = wr_dat[OC_GREV];
        end
        IDX_ENTRY: begin
          d.cfg.scan_step_direction = wr_dat[EN_DIR +: 2];
          d.cfg.image_enhancer = wr_dat[EN_ENH];
        end
        IDX_IFACE: begin
          d.cfg.if_mode = wr_dat[IF_MODE +: 2];
          d.cfg.enable_polarity = wr_dat[IF_POL];
        end
        IDX_POWER: begin
          d.cfg.standby = wr_dat[PW_STBY];
          d.cfg.ext_clk_sel = wr_dat[PW_EXTCLK];
        end
        IDX_ADDR_SET: begin
          d.pixel_address_counter = wr_dat[ADR_W-1:0];
          d.frame_base = wr_dat[ADR_W-1:0];
        end
        IDX_H_START: d.cfg.h_start = wr_dat[COL_W-1:0];
        IDX_H_END:   d.cfg.h_end = wr_dat[COL_W-1:0];
        IDX_V_START: d.cfg.v_start = wr_dat[ROW_W-1:0];
        IDX_V_END:   d.cfg.v_end = wr_dat[ROW_W-1:0];
        default: ;
      endcase
    end
    // Read data stands only in the cycle after the strobe.
    d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        IDX_STATUS:   d.rdata = {q.st == RF_SYNC, q.st == RF_HALT, 7'h00, q.rf_row};
        IDX_OUT_CTRL: d.rdata = 18'({q.cfg.gate_scan_reverse, q.cfg.colour_order_swap,
                                     q.cfg.source_reverse});
        IDX_ENTRY:    d.rdata = 18'({q.cfg.image_enhancer, 2'h0, q.cfg.scan_step_direction});
        IDX_IFACE:    d.rdata = 18'({q.cfg.enable_polarity, q.cfg.if_mode});
        IDX_POWER:    d.rdata = 18'({q.cfg.ext_clk_sel, q.cfg.standby});
        IDX_ADDR_SET: d.rdata = 18'(q.pixel_address_counter);
        IDX_GRAPHICS_MEMORY: begin
          if (q.pixel_address_counter[16:8] <= ROW_LAST
              && q.pixel_address_counter[7:0] <= COL_LAST) begin
            d.rdata = graphics_memory[graphics_memory_index(q.pixel_address_counter)];
          end
        end
        IDX_H_START:  d.rdata = 18'(q.cfg.h_start);
        IDX_H_END:    d.rdata = 18'(q.cfg.h_end);
        IDX_V_START:  d.rdata = 18'(q.cfg.v_start);
        IDX_V_END:    d.rdata = 18'(q.cfg.v_end);
        default:      d.rdata = '0;
      endcase
    end
    // Refresh scan: one pixel per cycle into the source latch.
    rf_pix = '{q.st == RF_SCAN && !q.cfg.standby, q.rf_col,
               graphics_memory[graphics_memory_index({q.rf_row, q.rf_col})]};
    case (q.st)
      RF_SCAN: begin
        if (q.cfg.standby) begin
          d.st = RF_HALT;
        end else if (q.rf_col == COL_LAST) begin
          d.rf_col = '0;
          d.gate_row = q.rf_row;
          d.gate_valid = 1'b1;
          d.gate_on = '0;
          d.gate_on[q.cfg.gate_scan_reverse ? ROW_LAST - q.rf_row : q.rf_row] = 1'b1;
          if (q.rf_row == ROW_LAST) begin
            d.rf_row = '0;
            if (q.cfg.if_mode == IF_VSYNC) d.st = RF_SYNC;
          end else begin
            d.rf_row = q.rf_row + 9'h001;
          end
        end else begin
          d.rf_col = q.rf_col + 8'h01;
        end
      end
      RF_SYNC: begin
        if (q.cfg.standby) d.st = RF_HALT;
        else if (fs_fall || q.cfg.if_mode != IF_VSYNC) d.st = RF_SCAN;
      end
      RF_HALT: begin
        d.rf_col = '0;
        d.rf_row = '0;
        if (!q.cfg.standby) d.st = RF_SCAN;
      end
      default: d.st = RF_HALT;
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.cfg <= CFG_RST;
      q.st <= RF_SCAN;
      // Write strobe history resets to its idle high level, so a host that
      // holds select low across reset does not see a false rising edge.
      q.hs1.write_n <= 1'b1;
      q.hs2.write_n <= 1'b1;
      q.hwr_prev <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // pixel storage, one word per address.
  always_ff @(posedge clk) begin
    if (clk_en && graphics_memory_we) begin
      graphics_memory[graphics_memory_index(q.pixel_address_counter)] <= graphics_memory_wdata;
    end
  end

  source_line_latch #(.N_COLS(N_COLS)) u_latch (
    .clk               (clk),
    .nrst              (nrst),
    .clk_en            (clk_en),
    .pix               (rf_pix),
    .source_reverse    (q.cfg.source_reverse),
    .colour_order_swap (q.cfg.colour_order_swap),
    .source_out        (source_out),
    .line_latched      (line_latched)
  );

  assign reg_rdata = q.rdata;
  assign gate_on   = q.gate_on;
  assign osc_enable    = !q.cfg.standby && !q.cfg.ext_clk_sel;
  assign ext_clock_sel = q.cfg.ext_clk_sel;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_addr_set;
    clk_en && reg_wr && reg_addr == IDX_ADDR_SET && q.cfg.if_mode == IF_SYS;
  endsequence
  sequence s_bus_pixel;
    clk_en && reg_wr && reg_addr == IDX_GRAPHICS_MEMORY && q.cfg.if_mode == IF_SYS
      && q.cfg.scan_step_direction == 2'h3;
  endsequence

  property p_addr_load;
    @(posedge clk) disable iff (!nrst)
      s_addr_set |=> q.pixel_address_counter == $past(reg_wdata[16:0]);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address not loaded");

  property p_step;
    @(posedge clk) disable iff (!nrst)
      s_bus_pixel ##0 (q.pixel_address_counter[7:0] < q.cfg.h_end)
        |=> q.pixel_address_counter == $past(q.pixel_address_counter) + 17'h00001;
  endproperty
  a_step: assert property (p_step) else $error("counter did not step by one");

  property p_wrap;
    @(posedge clk) disable iff (!nrst)
      s_bus_pixel ##0 (q.pixel_address_counter[7:0] == q.cfg.h_end)
        |=> q.pixel_address_counter[7:0] == $past(q.cfg.h_start);
  endproperty
  a_wrap: assert property (p_wrap) else $error("column did not wrap");

  property p_read_hold;
    @(posedge clk) disable iff (!nrst)
      (clk_en && reg_rd && !reg_wr && !host_fire && q.cfg.if_mode == IF_SYS)
        |=> $stable(q.pixel_address_counter);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read moved counter");

  property p_window;
    @(posedge clk) disable iff (!nrst)
      graphics_memory_we |-> in_window(q.pixel_address_counter, q.cfg);
  endproperty
  a_window: assert property (p_window) else $error("write outside window");

  property p_csel;
    @(posedge clk) disable iff (!nrst)
      q.hs2.select_n |-> !host_fire;
  endproperty
  a_csel: assert property (p_csel) else $error("host strobe taken while deselected");

  property p_epl;
    @(posedge clk) disable iff (!nrst)
      rgb_go |-> q.rs2.enable == q.cfg.enable_polarity && q.rs2.valid;
  endproperty
  a_epl: assert property (p_epl) else $error("rgb pixel taken at wrong enable");

  property p_osc;
    @(posedge clk) disable iff (!nrst)
      q.cfg.standby |-> !osc_enable;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator runs in standby");

  property p_gate;
    @(posedge clk) disable iff (!nrst)
      $onehot0(gate_on);
  endproperty
  a_gate: assert property (p_gate) else $error("more than one gate on");

  property p_sync_wait;
    @(posedge clk) disable iff (!nrst)
      (clk_en && q.st == RF_SYNC && !fs_fall && !q.cfg.standby
        && q.cfg.if_mode == IF_VSYNC) |=> q.st == RF_SYNC;
  endproperty
  a_sync_wait: assert property (p_sync_wait) else $error("frame began without sync");

endmodule

//--- hw/source_line_latch.sv
`timescale 1ns/1ns
module source_line_latch
  import graphics_memory_pkg::*;
#(
  parameter int N_COLS = COLS
) (
  input  wire logic                        clk,               // System clock.
  input  wire logic                        nrst,              // Async reset, low.
  input  wire logic                        clk_en,            // Freezes state when low.
  input  wire pixel_s                      pix,               // Refresh pixel stream.
  input  wire logic                        source_reverse,    // Mirror triplet order.
  input  wire logic                        colour_order_swap, // Swap red and blue.
  output logic [N_COLS*3*CH_W-1:0]         source_out,        // Latched channels.
  output logic                             line_latched       // Pulse on new line.
);

  localparam logic [COL_W-1:0] LAST = COL_W'(N_COLS - 1);

  typedef struct packed {
    logic [N_COLS-1:0][PIX_W-1:0] acc;
    logic [COL_W-1:0]             cnt;
    logic [N_COLS*3*CH_W-1:0]     src;
    logic                         done;
  } latch_s;

  latch_s q;
  latch_s d;

  ////////////////////////////////////////////////////////////////////////////
  // Gather a whole line, then swap it onto the outputs in one step so that
  // the drivers never show a half-updated line.
  always_comb begin
    int t;
    t = 0;
    d = q;
    d.done = 1'b0;
    if (pix.valid) begin
      d.acc[pix.col] = pix.data;
      d.cnt = (pix.col == '0) ? 8'h01 : q.cnt + 8'h01;
      if (q.cnt == LAST && pix.col == LAST) begin
        d.done = 1'b1;
        for (int c = 0; c < N_COLS; c++) begin
          t = source_reverse ? N_COLS - 1 - c : c;
          d.src[t*3*CH_W +: CH_W] = colour_order_swap ? d.acc[c][5:0] : d.acc[c][17:12];
          d.src[(t*3+1)*CH_W +: CH_W] = d.acc[c][11:6];
          d.src[(t*3+2)*CH_W +: CH_W] = colour_order_swap ? d.acc[c][17:12] : d.acc[c][5:0];
        end
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign source_out   = q.src;
  assign line_latched = q.done;

  property p_latch_full;
    @(posedge clk) disable iff (!nrst)
      $rose(q.done) |-> ($past(q.cnt) == LAST && $past(pix.valid));
  endproperty
  a_latch_full: assert property (p_latch_full) else $error("line latched early");

  property p_latch_hold;
    @(posedge clk) disable iff (!nrst)
      !q.done |-> ($stable(q.src) || !$past(nrst));
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("source moved mid line");

endmodule

//--- pkg/graphics_memory_pkg.sv
package graphics_memory_pkg;

  // Panel geometry and word widths.
  localparam int COLS  = 240;
  localparam int ROWS  = 320;
  localparam int PIX_W = 18;
  localparam int CH_W  = 6;
  localparam int COL_W = 8;
  localparam int ROW_W = 9;
  localparam int ADR_W = 17;

  // Register indexes on the software port.
  localparam logic [7:0] IDX_STATUS   = 8'h00;
  localparam logic [7:0] IDX_OUT_CTRL = 8'h01;
  localparam logic [7:0] IDX_ENTRY    = 8'h03;
  localparam logic [7:0] IDX_IFACE    = 8'h0C;
  localparam logic [7:0] IDX_POWER    = 8'h10;
  localparam logic [7:0] IDX_ADDR_SET = 8'h20;
  localparam logic [7:0] IDX_GRAPHICS_MEMORY     = 8'h22;
  localparam logic [7:0] IDX_H_START  = 8'h50;
  localparam logic [7:0] IDX_H_END    = 8'h51;
  localparam logic [7:0] IDX_V_START  = 8'h52;
  localparam logic [7:0] IDX_V_END    = 8'h53;

  // Field positions.
  localparam int OC_SRC_REV = 0;
  localparam int OC_SWAP    = 1;
  localparam int OC_GREV    = 2;
  localparam int EN_DIR     = 0;
  localparam int EN_ENH     = 4;
  localparam int IF_MODE    = 0;
  localparam int IF_POL     = 2;
  localparam int PW_STBY    = 0;
  localparam int PW_EXTCLK  = 1;

  // Interface mode field values.
  localparam logic [1:0] IF_SYS   = 2'h0;
  localparam logic [1:0] IF_RGB   = 2'h1;
  localparam logic [1:0] IF_VSYNC = 2'h2;

  // Enhancer offset and saturation point of the stretched value.
  localparam logic [7:0] ENH_OFS = 8'h08;
  localparam logic [7:0] ENH_SAT = 8'h47;

  typedef enum logic [2:0] {
    RF_SCAN = 3'b001,
    RF_SYNC = 3'b010,
    RF_HALT = 3'b100
  } refresh_e;

  typedef struct packed {
    logic             source_reverse;
    logic             colour_order_swap;
    logic             gate_scan_reverse;
    logic [1:0]       scan_step_direction;
    logic             image_enhancer;
    logic [1:0]       if_mode;
    logic             enable_polarity;
    logic             standby;
    logic             ext_clk_sel;
    logic [COL_W-1:0] h_start;
    logic [COL_W-1:0] h_end;
    logic [ROW_W-1:0] v_start;
    logic [ROW_W-1:0] v_end;
  } cfg_s;

  localparam cfg_s CFG_RST = '{source_reverse: 1'b0, colour_order_swap: 1'b0,
    gate_scan_reverse: 1'b0, scan_step_direction: 2'h3, image_enhancer: 1'b0,
    if_mode: IF_SYS, enable_polarity: 1'b0, standby: 1'b0, ext_clk_sel: 1'b0,
    h_start: 8'h00, h_end: 8'hEF, v_start: 9'h000, v_end: 9'h13F};

  typedef struct packed {
    logic             select_n;
    logic             write_n;
    logic             rs;
    logic [PIX_W-1:0] data;
  } host_pins_s;

  typedef struct packed {
    logic             pclk;
    logic             enable;
    logic             valid;
    logic             fsync_n;
    logic [PIX_W-1:0] bus;
  } rgb_pins_s;

  typedef struct packed {
    logic             valid;
    logic [COL_W-1:0] col;
    logic [PIX_W-1:0] data;
  } pixel_s;

endpackage

//--- tb/graphics_memory_write_path_bench.sv
`timescale 1ns/1ns
module graphics_memory_write_path_bench;
  import graphics_memory_pkg::*;
  logic             clk = 0, nrst = 0, en = 1, reg_wr = 0, reg_rd = 0;
  logic             sel_n, wr_n, rs, osc, ll, ext;
  logic             pclk = 0, rgb_en = 0, vld = 0, fs_n = 1;
  logic [7:0]       reg_addr = 0;
  logic [PIX_W-1:0] reg_wdata = 0, reg_rdata, hd, v, d1, d2, pbus = 0;
  logic [ROWS-1:0]  gate_on;
  logic [COLS*3*CH_W-1:0] src;
  int               fail_count = 0, num_checks = 0, exp_addr = 0;
  // Free-running 20 MHz clock.
  always #25 clk = ~clk;
  host_model hm (.clk(clk), .sel_n(sel_n), .wr_n(wr_n), .rs(rs), .data(hd));
  graphics_memory_write_path dut (.clk(clk), .nrst(nrst), .clk_en(en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .host_select_n(sel_n), .host_write_n(wr_n), .host_rs(rs), .host_data(hd),
    .pixel_clock(pclk), .rgb_enable(rgb_en), .pixel_valid(vld), .frame_sync_n(fs_n),
    .rgb_pixel_bus(pbus), .source_out(src), .gate_on(gate_on), .line_latched(ll),
    .osc_enable(osc), .ext_clock_sel(ext));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [PIX_W-1:0] seen, input logic [PIX_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [PIX_W-1:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rd(input logic [7:0] a, output logic [PIX_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic setad(input int a);
    wr(IDX_ADDR_SET, 18'(a));
    exp_addr = a;
  endtask
  // Model step: column climbs, past column EFh it moves to the next line.
  // step model
  task automatic px(input logic [PIX_W-1:0] d);
    wr(IDX_GRAPHICS_MEMORY, d);
    exp_addr = ((exp_addr & 'hFF) == 'hEF) ? (exp_addr & ~'hFF) + 'h100 : exp_addr + 1;
  endtask
  task automatic chk_addr();
    rd(IDX_ADDR_SET, v);
    check(v, 18'(exp_addr));
  endtask
  // One dot-clock pulse: four system clocks low, four high, four low, data steady around the rise.
  // qualified rgb pixel
  task automatic rgb_px(input logic e, input logic [PIX_W-1:0] p);
    @(posedge clk);
    rgb_en <= e;
    vld    <= 1'b1;
    pbus   <= p;
    repeat (4) @(posedge clk);
    pclk <= 1'b1;
    repeat (4) @(posedge clk);
    pclk <= 1'b0;
    vld  <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Put a pixel at column 0 of a line two ahead of the refresh scan, then
  // look at the outputs in the cycle in which that line is latched.
  task automatic line_chk(input logic rev, input logic [PIX_W-1:0] want);
    int r;
    int n;
    rd(IDX_STATUS, v);
    r = (int'(v[8:0]) + 2) % ROWS;
    n = 0;
    setad(r * 256);
    px(d1);
    while (gate_on[rev ? ROWS - 1 - r : r] !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    check(18'(ll), 18'h00001);
    check(18'(gate_on[rev ? ROWS - 1 - r : r]), 18'h00001);
    check(src[(rev ? (COLS - 1) * 3 * CH_W : 0) +: PIX_W], want);
  endtask
  function automatic logic [PIX_W-1:0] enh(input logic [PIX_W-1:0] p);
    int e;
    for (int k = 0; k < 3; k++) begin
      e = p[6*k+:6] + p[6*k+:6] / 4 - 8;
      enh[6*k+:6] = 6'(e < 0 ? 0 : (e > 63 ? 63 : e));
    end
  endfunction
  // Watchdog: the whole sequence needs well under a millisecond.
  initial begin
    #2000000;
    fail_count++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(25));
    repeat (10) @(posedge clk);
    check(18'(osc), 18'h1);
    nrst <= 1'b1;
    chk_addr();
    // An address-set write while the clock enable is low is not taken.
    @(posedge clk);
    en <= 1'b0;
    wr(IDX_ADDR_SET, 18'h00055);
    en <= 1'b1;
    chk_addr();
    // Two writes across the end of line 0: the first stays on line 0, the second lands on line 1.
    d1 = 18'($urandom);
    d2 = 18'($urandom);
    setad('hEF);
    px(d1);
    px(d2);
    chk_addr();
    setad('hEF);
    rd(IDX_GRAPHICS_MEMORY, v);
    check(v, d1);
    chk_addr();
    setad('h100);
    rd(IDX_GRAPHICS_MEMORY, v);
    check(v, d2);
    setad('h13F00);
    px(d1);
    setad('h13F00);
    rd(IDX_GRAPHICS_MEMORY, v);
    check(v, d1);
    // Refresh path: red channel lands on the lowest output of the triplet.
    line_chk(1'b0, {d1[5:0], d1[11:6], d1[17:12]});
    wr(IDX_OUT_CTRL, 18'h00007);
    rd(IDX_OUT_CTRL, v);
    check(v, 18'h00007);
    line_chk(1'b1, d1);
    wr(IDX_OUT_CTRL, 18'h00000);
    $display("test counter done");
    // Host pins: selected write steps, deselected write is ignored.
    setad('h205);
    hm.write(1'b0, 1'b0, 18'(IDX_GRAPHICS_MEMORY));
    hm.write(1'b0, 1'b1, d2);
    exp_addr++;
    hm.write(1'b1, 1'b1, d1);
    chk_addr();
    setad('h205);
    rd(IDX_GRAPHICS_MEMORY, v);
    check(v, d2);
    // A write outside a narrowed window leaves memory alone.
    wr(IDX_H_START, 18'h00010);
    wr(IDX_H_END, 18'h00020);
    setad('h205);
    px(d1);
    wr(IDX_H_START, 18'h00000);
    wr(IDX_H_END, 18'h000EF);
    setad('h205);
    rd(IDX_GRAPHICS_MEMORY, v);
    check(v, d2);
    $display("test host done");
    wr(IDX_ENTRY, 18'h00013);
    setad('h300);
    px(d1);
    setad('h300);
    rd(IDX_GRAPHICS_MEMORY, v);
    check(v, enh(d1));
    $display("test enhance done");
    // RGB port with high enable level: a qualified pixel steps the counter,
    // a pixel at the wrong enable level is dropped, a frame sync reloads.
    setad('h400);
    wr(IDX_IFACE, 18'h00005);
    rgb_px(1'b1, d2);
    exp_addr++;
    chk_addr();
    rgb_px(1'b0, d1);
    chk_addr();
    @(posedge clk);
    fs_n <= 1'b0;
    repeat (4) @(posedge clk);
    fs_n <= 1'b1;
    exp_addr = 'h400;
    chk_addr();
    rd(IDX_GRAPHICS_MEMORY, v);
    check(v, enh(d2));
    wr(IDX_IFACE, 18'h00000);
    $display("test rgb done");
    wr(IDX_POWER, 18'h00003);
    repeat (3) @(posedge clk);
    check(18'(osc), 18'h0);
    check(18'(ext), 18'h00001);
    rd(IDX_STATUS, v);
    check(18'(v[16]), 18'h00001);
    $display("test power done");
    final_report();
  end
endmodule

//--- tb/host_model.sv
`timescale 1ns/1ns
module host_model
  import graphics_memory_pkg::*;
(
  input  wire logic        clk,   // System clock.
  output logic             sel_n, // Chip select, low.
  output logic             wr_n,  // Write strobe, taken on rise.
  output logic             rs,    // Low index, high data.
  output logic [PIX_W-1:0] data   // Data bus.
);
  initial begin
    sel_n = 1'b1;
    wr_n  = 1'b1;
    rs    = 1'b0;
    data  = '0;
  end
  // Each phase lasts four clocks so the pin synchroniser sees it.
  // select drives gating
  task automatic write(input logic s, input logic r, input logic [PIX_W-1:0] d);
    @(posedge clk);
    sel_n <= s;
    rs    <= r;
    data  <= d;
    wr_n  <= 1'b0;
    repeat (4) @(posedge clk);
    wr_n <= 1'b1;
    repeat (4) @(posedge clk);
    sel_n <= 1'b1;
    data  <= ~d;
  endtask
endmodule
